// *** logic/pmc_pkg.sv ***
/*
 * constants, states and carriers for the sleep and idle power mode controller.
 * assumes a single system clock domain and an ahb-lite register port.
 */
package pmc_pkg;
   // ==========================================
   // register offsets (byte addresses, low 8 bits decoded)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   // ==========================================
   // field positions
   localparam int CTRL_IDLE_BIT = 7;
   localparam int CTRL_FLAG_BIT = 3;
   localparam int CTRL_SEL_LSB = 0;
   localparam int STAT_CLK_LSB = 0;
   localparam int STAT_MODE_LSB = 8;
   // ==========================================
   // reset values
   localparam logic CTRL_IDLE_RST = 1'b0;
   localparam logic [1:0] CTRL_SEL_RST = 2'h0;
   localparam logic [3:0] CFG_RST = 4'h0;
   // ==========================================
   // clock source select encodings (1x = internal oscillator)
   localparam logic [1:0] SEL_PRI = 2'h0;
   localparam logic [1:0] SEL_SEC = 2'h1;
   localparam logic [1:0] SEL_INT = 2'h2;
   // ==========================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CSD_TIME_NS = 200;
   localparam int CSD_CYCLES = (CSD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================
   // types
   typedef enum logic [4:0] {
      ST_RUN = 5'b00001,
      ST_SLEEP = 5'b00010,
      ST_WAKE = 5'b00100,
      ST_IDLE = 5'b01000,
      ST_CSD = 5'b10000
   } pmc_state_e;
   typedef struct packed {
      logic pri;
      logic sec;
      logic intl;
   } pmc_osc_s;
   typedef struct packed {
      logic cpu;
      logic periph;
      logic [1:0] src;
   } pmc_gate_s;
   typedef struct packed {
      logic idle;
      logic [1:0] sel;
   } pmc_ctrl_s;
   typedef struct packed {
      logic fscm;
      logic two_speed;
      logic sec_en;
      logic wdt_sel;
   } pmc_cfg_s;
endpackage

// *** logic/pmc_power_mode_ctrl.sv ***
/*
 * sleep and idle power mode controller with ahb-lite register slave.
 * assumes power_down_exec, irq_wake and wdt_timeout come from logic on hclk,
 * and osc_ready comes from the analog oscillator block (resynchronised here).
 * device reset (hresetn) is itself a wake event: it returns the block to run.
 */
// Overview of operation
// RULE_01: power-down with idle bit clear enters sleep
// RULE_02: sleep stops selected oscillator, all clocks off
// RULE_03: sleep entry clears all clock status bits
// RULE_04: sleep entry needs no clock switch first
// RULE_05: watchdog selected keeps internal oscillator running
// RULE_06: enabled secondary timer oscillator keeps running
// RULE_07: sleep left only by interrupt, reset, watchdog
// RULE_08: after sleep wake, clocks held until source ready
// RULE_09: two-speed or fail-safe: run internal oscillator immediately
// RULE_10: primary running flag set once primary clocks device
// RULE_11: wake leaves idle bit and select unchanged
// RULE_12: power-down with idle bit set stops cpu only
// RULE_13: idle entry leaves clock status bits alone
// RULE_14: idle left only by interrupt, watchdog, reset
// RULE_15: idle wake delays cpu by start delay
// RULE_16: cpu resumes on the idle clock source
// RULE_17: watchdog timeout in low power wakes, not resets
// RULE_18: start delay is fixed parameterised cycle count
`timescale 1ns/1ns
module pmc_power_mode_ctrl #(
   parameter int CSD_COUNT = pmc_pkg::CSD_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic power_down_exec,
   input wire logic irq_wake,
   input wire logic wdt_timeout,
   input wire pmc_pkg::pmc_osc_s osc_ready,
   output pmc_pkg::pmc_osc_s osc_run,
   output pmc_pkg::pmc_gate_s clk_gate,
   output pmc_pkg::pmc_state_e mode
);
   localparam int CW = $clog2(CSD_COUNT + 1);
   localparam logic [CW-1:0] CSD_LAST = CW'(CSD_COUNT - 1);

   // ==========================================
   // state
   pmc_pkg::pmc_state_e state_ff, nxt_state;
   pmc_pkg::pmc_ctrl_s ctrl_ff, nxt_ctrl;
   pmc_pkg::pmc_cfg_s cfg_ff, nxt_cfg;
   pmc_pkg::pmc_osc_s stat_ff, nxt_stat;
   pmc_pkg::pmc_osc_s rdy_m_ff, nxt_rdy_m;
   pmc_pkg::pmc_osc_s rdy_ff, nxt_rdy;
   pmc_pkg::pmc_osc_s run_ff, nxt_run;
   pmc_pkg::pmc_gate_s gate_ff, nxt_gate;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic wr_ff, nxt_wr;
   logic [7:0] wa_ff, nxt_wa;
   logic [31:0] rd_ff, nxt_rd;
   logic wake;
   logic fast_start;
   logic sel_rdy;
   logic acc;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_ff;
   assign osc_run = run_ff;
   assign clk_gate = gate_ff;
   assign mode = state_ff;

   // ==========================================
   // next-state logic for bus, registers and mode machine
   always_comb begin
      nxt_state = state_ff;
      nxt_ctrl = ctrl_ff;
      nxt_cfg = cfg_ff;
      nxt_stat = stat_ff;
      nxt_cnt = cnt_ff;
      nxt_rd = rd_ff;
      // oscillator ready bits are analog, so two flops before use
      nxt_rdy_m = osc_ready;
      nxt_rdy = rdy_m_ff;
      wake = irq_wake | wdt_timeout; // RULE_07 RULE_14 RULE_17
      fast_start = cfg_ff.two_speed | cfg_ff.fscm;
      case (ctrl_ff.sel)
         pmc_pkg::SEL_PRI: sel_rdy = rdy_ff.pri;
         pmc_pkg::SEL_SEC: sel_rdy = rdy_ff.sec;
         default: sel_rdy = rdy_ff.intl;
      endcase

      // bus: zero-wait slave, write lands in the data phase
      acc = hsel & hready & htrans[1];
      nxt_wr = acc & hwrite;
      nxt_wa = haddr[7:0];
      // only bus writes touch ctrl, so no wake can alter it
      if (wr_ff) begin // RULE_11
         case (wa_ff)
            pmc_pkg::OFS_CTRL: begin
               nxt_ctrl.idle = hwdata[pmc_pkg::CTRL_IDLE_BIT];
               nxt_ctrl.sel = hwdata[pmc_pkg::CTRL_SEL_LSB +: 2];
            end
            pmc_pkg::OFS_CFG: nxt_cfg = hwdata[3:0];
            default: ;
         endcase
      end

      // mode machine
      case (state_ff)
         pmc_pkg::ST_RUN: begin
            if (power_down_exec && ctrl_ff.idle) begin
               nxt_state = pmc_pkg::ST_IDLE; // RULE_12 RULE_13
            end else if (power_down_exec) begin
               // straight to sleep, no switch, status wiped
               nxt_state = pmc_pkg::ST_SLEEP; // RULE_01 RULE_04
               nxt_stat = '0; // RULE_03
            end else begin
               // status shows what really clocks the device
               nxt_stat = '0;
               case (ctrl_ff.sel)
                  pmc_pkg::SEL_PRI: nxt_stat.pri = rdy_ff.pri; // RULE_10
                  pmc_pkg::SEL_SEC: nxt_stat.sec = rdy_ff.sec;
                  default: nxt_stat.intl = rdy_ff.intl;
               endcase
            end
         end
         pmc_pkg::ST_SLEEP: begin
            if (wake) begin
               nxt_state = pmc_pkg::ST_WAKE; // RULE_07 RULE_17
            end
         end
         pmc_pkg::ST_WAKE: begin
            if (sel_rdy) begin
               nxt_state = pmc_pkg::ST_RUN; // RULE_08
            end else if (fast_start) begin
               nxt_stat.intl = rdy_ff.intl; // RULE_09
            end
         end
         pmc_pkg::ST_IDLE: begin
            if (wake) begin
               nxt_state = pmc_pkg::ST_CSD; // RULE_14
               nxt_cnt = CSD_LAST; // RULE_15 RULE_18
            end
         end
         pmc_pkg::ST_CSD: begin
            if (cnt_ff == '0) begin
               nxt_state = pmc_pkg::ST_RUN; // RULE_16
            end else begin
               nxt_cnt = cnt_ff - CW'(1); // RULE_18
            end
         end
         default: nxt_state = pmc_pkg::ST_RUN;
      endcase

      // register read data from next values, so a read right after a write sees it
      if (acc && !hwrite) begin
         nxt_rd = 32'h0000_0000;
         case (haddr[7:0])
            pmc_pkg::OFS_CTRL: begin
               nxt_rd[pmc_pkg::CTRL_IDLE_BIT] = nxt_ctrl.idle;
               nxt_rd[pmc_pkg::CTRL_FLAG_BIT] = nxt_stat.pri;
               nxt_rd[pmc_pkg::CTRL_SEL_LSB +: 2] = nxt_ctrl.sel;
            end
            pmc_pkg::OFS_CFG: nxt_rd[3:0] = nxt_cfg;
            pmc_pkg::OFS_STAT: begin
               nxt_rd[pmc_pkg::STAT_CLK_LSB +: 3] = nxt_stat;
               nxt_rd[pmc_pkg::STAT_MODE_LSB +: 5] = nxt_state;
            end
            default: ;
         endcase
      end

      // clock gates follow the next mode
      nxt_gate.src = nxt_ctrl.sel;
      case (nxt_state)
         pmc_pkg::ST_RUN: begin
            nxt_gate.cpu = 1'b1;
            nxt_gate.periph = 1'b1;
         end
         pmc_pkg::ST_WAKE: begin
            // fast start runs on the internal oscillator until the source is ready
            nxt_gate.cpu = fast_start; // RULE_08 RULE_09
            nxt_gate.periph = fast_start;
            nxt_gate.src = fast_start ? pmc_pkg::SEL_INT : nxt_ctrl.sel;
         end
         pmc_pkg::ST_IDLE, pmc_pkg::ST_CSD: begin
            nxt_gate.cpu = 1'b0; // RULE_12 RULE_15
            nxt_gate.periph = 1'b1;
         end
         default: begin
            nxt_gate.cpu = 1'b0; // RULE_02
            nxt_gate.periph = 1'b0;
         end
      endcase

      // oscillator enables: selected one stops in sleep, kept ones stay up
      nxt_run.pri = (nxt_ctrl.sel == pmc_pkg::SEL_PRI) && (nxt_state != pmc_pkg::ST_SLEEP); // RULE_02
      nxt_run.sec = nxt_cfg.sec_en; // RULE_06
      nxt_run.intl = nxt_cfg.wdt_sel // RULE_05
                   | (nxt_ctrl.sel[1] && (nxt_state != pmc_pkg::ST_SLEEP))
                   | ((nxt_state == pmc_pkg::ST_WAKE) && fast_start); // RULE_09
   end

   // ==========================================
   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= pmc_pkg::ST_RUN;
         ctrl_ff <= '{idle: pmc_pkg::CTRL_IDLE_RST, sel: pmc_pkg::CTRL_SEL_RST}; // RULE_01
         cfg_ff <= pmc_pkg::CFG_RST;
         stat_ff <= '0;
         rdy_m_ff <= '0;
         rdy_ff <= '0;
         run_ff <= '{pri: 1'b1, sec: 1'b0, intl: 1'b0};
         gate_ff <= '{cpu: 1'b1, periph: 1'b1, src: pmc_pkg::CTRL_SEL_RST};
         cnt_ff <= '0;
         wr_ff <= 1'b0;
         wa_ff <= 8'h00;
         rd_ff <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         ctrl_ff <= nxt_ctrl;
         cfg_ff <= nxt_cfg;
         stat_ff <= nxt_stat;
         rdy_m_ff <= nxt_rdy_m;
         rdy_ff <= nxt_rdy;
         run_ff <= nxt_run;
         gate_ff <= nxt_gate;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         wa_ff <= nxt_wa;
         rd_ff <= nxt_rd;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_sleep_entry: assert property (state_ff == pmc_pkg::ST_RUN && power_down_exec && !ctrl_ff.idle // RULE_01
      |=> state_ff == pmc_pkg::ST_SLEEP ##0 !clk_gate.cpu) else $error("no sleep entry");
   a_sleep_clk_off: assert property (state_ff == pmc_pkg::ST_SLEEP // RULE_02
      |-> !clk_gate.cpu && !clk_gate.periph && (ctrl_ff.sel != pmc_pkg::SEL_PRI || !osc_run.pri))
      else $error("clock alive in sleep");
   a_sleep_stat_clr: assert property ($rose(state_ff == pmc_pkg::ST_SLEEP) |-> stat_ff == '0) // RULE_03
      else $error("status kept on sleep entry");
   a_direct_sleep: assert property (state_ff == pmc_pkg::ST_RUN && power_down_exec // RULE_04
      |=> state_ff inside {pmc_pkg::ST_SLEEP, pmc_pkg::ST_IDLE}) else $error("sleep entry delayed");
   a_int_osc_kept: assert property (cfg_ff.wdt_sel && !wr_ff // RULE_05
      |=> osc_run.intl) else $error("internal oscillator stopped");
   a_sec_osc_kept: assert property (cfg_ff.sec_en ##1 cfg_ff.sec_en |-> osc_run.sec) // RULE_06
      else $error("secondary oscillator stopped");
   a_sleep_hold: assert property (state_ff == pmc_pkg::ST_SLEEP && !irq_wake && !wdt_timeout // RULE_07
      |=> state_ff == pmc_pkg::ST_SLEEP) else $error("sleep left without wake");
   a_wake_gate: assert property (state_ff == pmc_pkg::ST_WAKE && !cfg_ff.two_speed && !cfg_ff.fscm // RULE_08
      |-> !clk_gate.cpu && !clk_gate.periph) else $error("clocked before source ready");
   a_fast_start: assert property (state_ff == pmc_pkg::ST_SLEEP && irq_wake && cfg_ff.two_speed // RULE_09
      && !wr_ff |=> clk_gate.cpu && clk_gate.src == pmc_pkg::SEL_INT) else $error("no fast start");
   a_flag_set: assert property (state_ff == pmc_pkg::ST_RUN && !power_down_exec && rdy_ff.pri // RULE_10
      && ctrl_ff.sel == pmc_pkg::SEL_PRI |=> stat_ff.pri) else $error("primary flag not set");
   a_ctrl_keep: assert property (!wr_ff |=> $stable(ctrl_ff)) else $error("ctrl changed by wake"); // RULE_11
   a_idle_gate: assert property (state_ff == pmc_pkg::ST_IDLE // RULE_12
      |-> !clk_gate.cpu && clk_gate.periph && clk_gate.src == ctrl_ff.sel) else $error("bad idle gating");
   a_idle_stat: assert property (state_ff == pmc_pkg::ST_RUN && power_down_exec && ctrl_ff.idle // RULE_13
      |=> $stable(stat_ff)) else $error("idle entry changed status");
   a_idle_hold: assert property (state_ff == pmc_pkg::ST_IDLE && !irq_wake && !wdt_timeout // RULE_14
      |=> state_ff == pmc_pkg::ST_IDLE) else $error("idle left without wake");
   a_csd_start: assert property (state_ff == pmc_pkg::ST_IDLE && wdt_timeout // RULE_15
      |=> state_ff == pmc_pkg::ST_CSD && cnt_ff == CSD_LAST && !clk_gate.cpu) else $error("no start delay");
   a_csd_count: assert property (state_ff == pmc_pkg::ST_CSD && cnt_ff != '0 // RULE_18
      |=> state_ff == pmc_pkg::ST_CSD && cnt_ff == $past(cnt_ff) - CW'(1) && clk_gate.periph)
      else $error("start delay miscounted");
   a_resume_src: assert property (state_ff == pmc_pkg::ST_CSD && cnt_ff == '0 && !wr_ff // RULE_16
      |=> clk_gate.cpu && clk_gate.src == ctrl_ff.sel) else $error("resumed on wrong source");
   a_wdt_wake: assert property (state_ff == pmc_pkg::ST_SLEEP && wdt_timeout // RULE_17
      |=> state_ff == pmc_pkg::ST_WAKE) else $error("watchdog did not wake");

   // ==========================================
   // further guards on entry, wake-wait, start delay gating and kept oscillators
   a_idle_entry: assert property (state_ff == pmc_pkg::ST_RUN && power_down_exec && ctrl_ff.idle // RULE_12
      |=> state_ff == pmc_pkg::ST_IDLE && clk_gate.periph) else $error("no idle entry");
   a_wake_run: assert property (state_ff == pmc_pkg::ST_WAKE && sel_rdy // RULE_08
      |=> state_ff == pmc_pkg::ST_RUN && clk_gate.cpu) else $error("no run after source ready");
   a_wake_wait: assert property (state_ff == pmc_pkg::ST_WAKE && !sel_rdy // RULE_08
      |=> state_ff == pmc_pkg::ST_WAKE) else $error("wake wait left early");
   a_fast_stat: assert property (state_ff == pmc_pkg::ST_WAKE && fast_start && !sel_rdy // RULE_09
      |=> stat_ff.intl == $past(rdy_ff.intl)) else $error("internal status not tracked");
   a_csd_gate: assert property (state_ff == pmc_pkg::ST_CSD // RULE_15
      |-> !clk_gate.cpu && clk_gate.periph && clk_gate.src == ctrl_ff.sel) else $error("bad start delay gating");
   a_sleep_sec: assert property (state_ff == pmc_pkg::ST_SLEEP && cfg_ff.sec_en // RULE_06
      |-> osc_run.sec) else $error("secondary oscillator off in sleep");
   a_sleep_int: assert property (state_ff == pmc_pkg::ST_SLEEP && cfg_ff.wdt_sel // RULE_05
      |-> osc_run.intl) else $error("internal oscillator off in sleep");
endmodule

// *** tb/pmc_osc_model.sv ***
/*
 oscillator block model: each ready level follows its enable after a start-up count.
 assumes enables come from the controller on hclk; slow picks the longer start-up.
*/
`timescale 1ns/1ns
module pmc_osc_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   input wire pmc_pkg::pmc_osc_s osc_run,
   output pmc_pkg::pmc_osc_s osc_ready
);
   // ===================================
   // start-up counters
   logic [3:0] cnt_ff [3];
   // a stopped oscillator drops ready at the next hclk edge, so no stale level lingers
   always_ff @(posedge hclk or negedge hresetn) begin
      for (int i = 0; i < 3; i++) begin
         if (!hresetn || !osc_run[i]) begin
            cnt_ff[i] <= 4'h0;
         end else if (cnt_ff[i] != 4'hf) begin
            cnt_ff[i] <= cnt_ff[i] + 4'h1;
         end
      end
   end
   // ready only once the count reaches the start-up length
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         osc_ready[i] = cnt_ff[i] >= (slow ? 4'h8 : 4'h2);
      end
   end
endmodule

// *** tb/tb_top.sv ***
/*
 testbench for the power mode controller: bus tasks, mode scenarios, report.
 assumes the oscillator model on the far side and a 4-cycle start delay.
*/
`timescale 1ns/1ns
module tb_top;
   // ===================================
   // signals and instances
   localparam int CSD = 4;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rdv;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic pd = 1'b0, irq = 1'b0, wdt = 1'b0, hreadyout, hresp;
   pmc_pkg::pmc_osc_s osc_ready, osc_run;
   pmc_pkg::pmc_gate_s g;
   pmc_pkg::pmc_state_e mode;
   int errors = 0, checks = 0, cyc = 0, n;
   pmc_power_mode_ctrl #(.CSD_COUNT(CSD)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .power_down_exec(pd), .irq_wake(irq), .wdt_timeout(wdt), .osc_ready(osc_ready),
      .osc_run(osc_run), .clk_gate(g), .mode(mode));
   pmc_osc_model osc (.hclk(hclk), .hresetn(hresetn), .slow(slow), .osc_run(osc_run),
      .osc_ready(osc_ready));
   always #5 hclk = ~hclk;
   // hang guard: generous for the handful of short scenarios below
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         complete_run();
      end
   end
   // ===================================
   // shared tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one single transfer; waits on hready in both phases
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0000_00, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(nm, rdv, exp);
      check("bus resp", 32'(hresp), 32'h0000_0000);
   endtask
   // one-cycle strobe on a mode input; returns after the edge that took it
   task automatic pulse(input int which);
      @(posedge hclk);
      if (which == 0) pd <= 1'b1;
      else wdt <= 1'b1;
      @(posedge hclk);
      pd <= 1'b0;
      wdt <= 1'b0;
      #1;
   endtask
   task automatic wait_run();
      n = 0;
      while (mode !== pmc_pkg::ST_RUN && n < 60) begin
         @(posedge hclk);
         #1;
         n++;
      end
   endtask
   function automatic logic [31:0] stat(input pmc_pkg::pmc_state_e m, input logic [2:0] c);
      return {19'h0_0000, m, 5'h00, c};
   endfunction
   // ===================================
   // scenarios
   task automatic t_sleep();
      bus(1'b1, pmc_pkg::OFS_CFG, 32'h0000_0003);
      slow <= 1'b1;
      pulse(0);
      check("sleep mode", 32'(mode), 32'(pmc_pkg::ST_SLEEP));
      check("sleep gates", 32'({g.cpu, g.periph}), 32'h0000_0000);
      check("sleep osc", 32'(osc_run), 32'h0000_0003);
      rd("sleep stat", pmc_pkg::OFS_STAT, stat(pmc_pkg::ST_SLEEP, 3'h0));
      check("still asleep", 32'(mode), 32'(pmc_pkg::ST_SLEEP));
      @(posedge hclk);
      irq <= 1'b1;
      @(posedge hclk);
      #1;
      check("wake mode", 32'(mode), 32'(pmc_pkg::ST_WAKE));
      check("wake cpu off", 32'(g.cpu), 32'h0000_0000);
      wait_run();
      irq <= 1'b0;
      check("wake held", 32'(n > 5), 32'h0000_0001);
      check("run gates", 32'(g), 32'h0000_000c);
      rd("ctrl after wake", pmc_pkg::OFS_CTRL, 32'h0000_0008);
   endtask
   task automatic t_idle();
      slow <= 1'b0;
      bus(1'b1, pmc_pkg::OFS_CTRL, 32'h0000_0082);
      repeat (10) @(posedge hclk);
      rd("run stat", pmc_pkg::OFS_STAT, stat(pmc_pkg::ST_RUN, 3'h1));
      pulse(0);
      check("idle mode", 32'(mode), 32'(pmc_pkg::ST_IDLE));
      check("idle gates", 32'(g), 32'h0000_0006);
      rd("idle stat", pmc_pkg::OFS_STAT, stat(pmc_pkg::ST_IDLE, 3'h1));
      pulse(1);
      check("delay mode", 32'(mode), 32'(pmc_pkg::ST_CSD));
      check("delay gates", 32'(g), 32'h0000_0006);
      n = 0;
      while (mode === pmc_pkg::ST_CSD && n < 60) begin
         @(posedge hclk);
         #1;
         n++;
      end
      check("delay length", n, CSD);
      check("resume gates", 32'(g), 32'h0000_000e);
      rd("ctrl after idle", pmc_pkg::OFS_CTRL, 32'h0000_0082);
   endtask
   // secondary select with the fail-safe monitor on, woken by the watchdog
   task automatic t_sec();
      bus(1'b1, pmc_pkg::OFS_CFG, 32'h0000_000a);
      bus(1'b1, pmc_pkg::OFS_CTRL, 32'h0000_0001);
      repeat (10) @(posedge hclk);
      rd("sec stat", pmc_pkg::OFS_STAT, stat(pmc_pkg::ST_RUN, 3'h2));
      pulse(0);
      check("sec sleep osc", 32'(osc_run), 32'h0000_0002);
      pulse(1);
      check("wdt wake mode", 32'(mode), 32'(pmc_pkg::ST_WAKE));
      check("monitor start", 32'(g), 32'h0000_000e);
      wait_run();
      check("sec run gates", 32'(g), 32'h0000_000d);
      rd("ctrl after sec", pmc_pkg::OFS_CTRL, 32'h0000_0001);
   endtask
   task automatic t_fast();
      bus(1'b1, pmc_pkg::OFS_CTRL, 32'h0000_0000);
      bus(1'b1, pmc_pkg::OFS_CFG, 32'h0000_0004);
      repeat (10) @(posedge hclk);
      pulse(0);
      check("direct sleep", 32'(mode), 32'(pmc_pkg::ST_SLEEP));
      @(posedge hclk);
      irq <= 1'b1;
      @(posedge hclk);
      #1;
      check("fast start", 32'({g.periph, g.src}), 32'h0000_0006);
      wait_run();
      irq <= 1'b0;
      pulse(0);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      #1;
      check("reset wake", 32'(mode), 32'(pmc_pkg::ST_RUN));
      @(posedge hclk);
      hresetn <= 1'b1;
      rd("cfg reset", pmc_pkg::OFS_CFG, 32'h0000_0000);
      rd("unmapped", 8'h0c, 32'h0000_0000);
   endtask
   // ===================================
   // main sequence
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (10) @(posedge hclk);
      rd("ctrl reset", pmc_pkg::OFS_CTRL, 32'h0000_0008);
      t_sleep();
      t_idle();
      t_sec();
      t_fast();
      complete_run();
   end
endmodule
